// ==== src/scc_pkg.sv ====
// constants and types for the stepper current chopper
//
// Notes on behaviour
// - drive until trip, decay, then drive again
// - torque code scales trip, zero gives 0.39%
// - standstill uses hold scale, same linear law
// - internal reference select overrides external reference
// - pin mode: external reference times sine only
// - fast decay reverses bridge, disables near zero
// - slow decay turns both low sides on
// - decay codes 000,100,101,110,111; 111 at reset
// - decay mode changes apply while running
// - slow decay repeats off time while above trip
// - mixed: 30% or 60% fast, then slow
// - dynamic: overshoot raises next fast fraction
// - dynamic: long drive lowers next fast fraction
// - dynamic: falling target forces full fast decay
// - off time 9/19/27/35 us, 19 default
// - blanking ignores comparator, sets minimum drive time
// - ripple mode: slow decay until valley level
package scc_pkg;
    localparam int CLK_MHZ = 100;

    // decay selection codes
    localparam logic [2:0] DECAY_SLOW    = 3'h0;
    localparam logic [2:0] DECAY_MIX30   = 3'h4;
    localparam logic [2:0] DECAY_MIX60   = 3'h5;
    localparam logic [2:0] DECAY_DYNAMIC = 3'h6;
    localparam logic [2:0] DECAY_RIPPLE  = 3'h7;
    localparam logic [2:0] DECAY_RESET   = DECAY_RIPPLE;

    // three-level decay pin codes
    localparam logic [1:0] PIN_LOW  = 2'h0;
    localparam logic [1:0] PIN_HIGH = 2'h1;
    localparam logic [1:0] PIN_OPEN = 2'h2;

    // off times in ns, least times so rounded up
    localparam int OFF0_NS = 9000;
    localparam int OFF1_NS = 19000;
    localparam int OFF2_NS = 27000;
    localparam int OFF3_NS = 35000;
    localparam logic [1:0] OFF_CFG_RESET = 2'h1;
    localparam logic [11:0] OFF0_CYC = 12'((OFF0_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] OFF1_CYC = 12'((OFF1_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] OFF2_CYC = 12'((OFF2_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] OFF3_CYC = 12'((OFF3_NS * CLK_MHZ + 999) / 1000);

    // blanking times in ns
    localparam int BLANK0_NS = 1000;
    localparam int BLANK1_NS = 1500;
    localparam int BLANK2_NS = 2000;
    localparam int BLANK3_NS = 2500;
    localparam logic [1:0] BLANK_CFG_RESET = 2'h1;
    localparam logic [11:0] BLANK0_CYC = 12'((BLANK0_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] BLANK1_CYC = 12'((BLANK1_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] BLANK2_CYC = 12'((BLANK2_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] BLANK3_CYC = 12'((BLANK3_NS * CLK_MHZ + 999) / 1000);

    // fast-decay fractions in percent
    localparam logic [6:0] PCT_MIX30  = 7'h1E;
    localparam logic [6:0] PCT_MIX60  = 7'h3C;
    localparam logic [6:0] PCT_FULL   = 7'h64;
    localparam logic [6:0] PCT_DYN_RESET = 7'h1E;

    // reference code of the internal 3.3 V reference (full scale)
    localparam logic [7:0] INT_REF_CODE = 8'hFF;

    typedef enum logic [2:0] {
        ST_DRIVE = 3'b000,
        ST_FAST  = 3'b001,
        ST_COAST = 3'b010,
        ST_SLOW  = 3'b011,
        ST_VALLEY = 3'b100
    } scc_state_e;
endpackage

// ==== src/scc_chopper.sv ====
// PWM current chopper for one H-bridge
`timescale 1ns/1ps
module scc_chopper
    import scc_pkg::*;
#(
    parameter int LONG_DRIVE_CYC = 2000,
    parameter int DYN_STEP_PCT   = 10
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       serialMode,
    input  wire logic [7:0] torqueScale,
    input  wire logic [7:0] holdCurrentScale,
    input  wire logic [2:0] decaySelect,
    input  wire logic       intRefEn,
    input  wire logic [1:0] offIntervalCfg,
    input  wire logic [1:0] blankingCfg,
    input  wire logic [1:0] decayPinLow,
    input  wire logic [1:0] decayPinHigh,
    input  wire logic       holding,
    input  wire logic [7:0] extRefCode,
    input  wire logic [7:0] sineWeight,
    input  wire logic       direction,
    input  wire logic       tripCurrent,
    input  wire logic       valleyCurrent,
    input  wire logic       nearZero,
    output logic [7:0]      tripLevel,
    output logic            out1High,
    output logic            out1Low,
    output logic            out2High,
    output logic            out2Low,
    output logic [2:0]      phase,
    output logic [6:0]      fastPct
);
    // refused at elaboration; the drive counter saturates at 4095, so stay below it
    if (LONG_DRIVE_CYC < 1 || LONG_DRIVE_CYC > 4094 || DYN_STEP_PCT < 1 || DYN_STEP_PCT > 50) begin
        $error("scc_chopper: parameter out of range");
    end

    localparam logic [11:0] LONG_CYC = 12'(LONG_DRIVE_CYC);
    localparam logic [6:0]  STEP_PCT = 7'(DYN_STEP_PCT);

    scc_state_e  state_reg;
    logic [11:0] cnt_reg;
    logic [11:0] offLen_reg;
    logic [11:0] fastLen_reg;
    logic [6:0]  dynPct_reg;
    logic        falling_reg;
    logic [7:0]  tripLevel_reg;
    logic [7:0]  tripLevel_next;
    logic [2:0]  mode;
    logic [11:0] offCyc;
    logic [11:0] blankCyc;
    logic [6:0]  modePct;
    logic [18:0] fastProd;
    logic [23:0] refProd;
    logic [7:0]  refSel;
    logic [7:0]  scaleSel;
    logic        blankDone;

    // effective mode; pins decode in pin mode, any other pair falls back to reset mode
    always_comb begin
        mode = DECAY_RESET;
        if (serialMode) begin
            mode = decaySelect;
        end else begin
            case ({decayPinLow, decayPinHigh})
                {PIN_OPEN, PIN_HIGH}: mode = DECAY_SLOW;
                {PIN_HIGH, PIN_LOW}:  mode = DECAY_MIX30;
                {PIN_OPEN, PIN_LOW}:  mode = DECAY_MIX60;
                {PIN_LOW,  PIN_LOW}:  mode = DECAY_DYNAMIC;
                {PIN_LOW,  PIN_HIGH}: mode = DECAY_RIPPLE;
                default:              mode = DECAY_RESET;
            endcase
        end
    end

    // off and blanking lengths; pin mode fixes blanking at its default
    always_comb begin
        case (offIntervalCfg)
            2'h0:    offCyc = OFF0_CYC;
            2'h1:    offCyc = OFF1_CYC;
            2'h2:    offCyc = OFF2_CYC;
            default: offCyc = OFF3_CYC;
        endcase
        case (serialMode ? blankingCfg : BLANK_CFG_RESET)
            2'h0:    blankCyc = BLANK0_CYC;
            2'h1:    blankCyc = BLANK1_CYC;
            2'h2:    blankCyc = BLANK2_CYC;
            default: blankCyc = BLANK3_CYC;
        endcase
    end

    // fast share of this off time; in dynamic mode a falling target takes it all
    always_comb begin
        case (mode)
            DECAY_MIX30:   modePct = PCT_MIX30;
            DECAY_MIX60:   modePct = PCT_MIX60;
            DECAY_DYNAMIC: modePct = falling_reg ? PCT_FULL : dynPct_reg;
            default:       modePct = 7'h00;
        endcase
        fastProd = 19'(offCyc) * 19'(modePct);
    end

    // trip level: serial mode reference x sine x (code+1)/256, so code zero still gives 1/256; pin mode external reference x sine/256
    always_comb begin
        refSel   = (serialMode && intRefEn) ? INT_REF_CODE : extRefCode;
        scaleSel = holding ? holdCurrentScale : torqueScale;
        if (serialMode) begin
            refProd = 24'(refSel) * 24'(sineWeight) * (24'(scaleSel) + 24'h000001);
        end else begin
            refProd = {8'h00, 16'(extRefCode) * 16'(sineWeight)};
            refProd = refProd << 8;
        end
        tripLevel_next = refProd[23:16];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tripLevel_reg <= 8'h00;
        end else begin
            tripLevel_reg <= tripLevel_next;
        end
    end

    // a drop in target is held until the next trip uses it, so a drop in the off time is kept
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            falling_reg <= 1'b0;
        end else if (tripLevel_next < tripLevel_reg) begin
            falling_reg <= 1'b1;
        end else if (state_reg == ST_DRIVE && blankDone && tripCurrent) begin
            falling_reg <= 1'b0;
        end
    end

    // comparator is only looked at after blanking, which is also the least drive time
    assign blankDone = (cnt_reg >= blankCyc);

    // chopping sequence, intervals counted in clocks
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg   <= ST_DRIVE;
            cnt_reg     <= 12'h000;
            offLen_reg  <= OFF1_CYC;
            fastLen_reg <= 12'h000;
        end else begin
            case (state_reg)
                ST_DRIVE: begin
                    if (blankDone && tripCurrent) begin
                        cnt_reg     <= 12'h000;
                        offLen_reg  <= offCyc;
                        fastLen_reg <= 12'(fastProd / 19'd100);
                        if (mode == DECAY_RIPPLE)
                            state_reg <= ST_VALLEY;
                        else if (mode == DECAY_SLOW || fastProd < 19'd100)
                            state_reg <= ST_SLOW;
                        else
                            state_reg <= ST_FAST;
                    end else if (cnt_reg != 12'hFFF) begin
                        cnt_reg <= cnt_reg + 12'h001;
                    end
                end
                ST_FAST, ST_COAST: begin
                    cnt_reg <= cnt_reg + 12'h001;
                    if (cnt_reg + 12'h001 >= offLen_reg) begin
                        state_reg <= ST_DRIVE;
                        cnt_reg   <= 12'h000;
                    end else if (cnt_reg + 12'h001 >= fastLen_reg) begin
                        state_reg <= ST_SLOW;
                    end else if (nearZero) begin
                        state_reg <= ST_COAST;
                    end
                end
                ST_SLOW: begin
                    cnt_reg <= cnt_reg + 12'h001;
                    if (cnt_reg + 12'h001 >= offLen_reg) begin
                        cnt_reg <= 12'h000;
                        // still above trip in slow decay: run another whole off time
                        if (mode == DECAY_SLOW && tripCurrent)
                            state_reg <= ST_SLOW;
                        else
                            state_reg <= ST_DRIVE;
                    end
                end
                ST_VALLEY: begin
                    cnt_reg <= 12'h000;
                    if (valleyCurrent || mode != DECAY_RIPPLE)
                        state_reg <= ST_DRIVE;
                end
                default: begin
                    state_reg <= ST_DRIVE;
                    cnt_reg   <= 12'h000;
                end
            endcase
        end
    end

    // adaptive fraction, adjusted once per cycle at the trip, clamped 0..100
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dynPct_reg <= PCT_DYN_RESET;
        end else if (mode == DECAY_DYNAMIC && state_reg == ST_DRIVE
                     && blankDone && tripCurrent) begin
            if (cnt_reg == blankCyc) begin
                // already over trip when blanking ends: overshoot
                if (dynPct_reg > PCT_FULL - STEP_PCT)
                    dynPct_reg <= PCT_FULL;
                else
                    dynPct_reg <= dynPct_reg + STEP_PCT;
            end else if (cnt_reg > LONG_CYC) begin
                if (dynPct_reg < STEP_PCT)
                    dynPct_reg <= 7'h00;
                else
                    dynPct_reg <= dynPct_reg - STEP_PCT;
            end
        end
    end

    // bridge switches; the coast state opens every switch to stop reverse current
    always_comb begin
        out1High = 1'b0;
        out1Low  = 1'b0;
        out2High = 1'b0;
        out2Low  = 1'b0;
        case (state_reg)
            ST_DRIVE: begin
                out1High = direction;
                out2Low  = direction;
                out2High = !direction;
                out1Low  = !direction;
            end
            ST_FAST: begin
                out2High = direction;
                out1Low  = direction;
                out1High = !direction;
                out2Low  = !direction;
            end
            ST_SLOW, ST_VALLEY: begin
                out1Low = 1'b1;
                out2Low = 1'b1;
            end
            default: begin
                out1Low = 1'b0;
            end
        endcase
    end

    assign tripLevel = tripLevel_reg;
    assign phase     = state_reg;
    assign fastPct   = dynPct_reg;
endmodule

// ==== dv/scc_chopper_assertions.sv ====
// port checks for the current chopper
`timescale 1ns/1ps
module scc_chopper_assertions
    import scc_pkg::*;
(
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       serialMode,
    input wire logic [7:0] torqueScale,
    input wire logic       intRefEn,
    input wire logic       holding,
    input wire logic [7:0] extRefCode,
    input wire logic [7:0] sineWeight,
    input wire logic       direction,
    input wire logic       tripCurrent,
    input wire logic       valleyCurrent,
    input wire logic [7:0] tripLevel,
    input wire logic       out1High,
    input wire logic       out1Low,
    input wire logic       out2High,
    input wire logic       out2Low,
    input wire logic [2:0] phase
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [11:0] driveCnt;
    // 32-bit product so the serial reference law never overflows
    function automatic logic [7:0] lvl(logic [7:0] r, logic [7:0] s, logic [7:0] k);
        return 8'((32'(r) * 32'(s) * (32'(k) + 32'h1)) >> 16);
    endfunction
    // cycles spent in drive, saturating so a long hold cannot wrap
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) driveCnt <= 12'h000;
        else if (phase != 3'h0) driveCnt <= 12'h000;
        else if (driveCnt != 12'hFFF) driveCnt <= driveCnt + 12'h001;
    end
    // drive ending and the first decay cycle, same polarity request
    sequence s_drive_to_fast;
        phase == 3'h0 ##1 (phase == 3'h1 && $stable(direction));
    endsequence
    property p_slow; phase == 3'h3 |-> out1Low && out2Low && !out1High && !out2High; endproperty
    a_slow: assert property (p_slow) else $error("slow decay switch pattern wrong");
    property p_coast; phase == 3'h2 |-> !(out1Low || out2Low || out1High || out2High); endproperty
    a_coast: assert property (p_coast) else $error("coast leaves a switch on");
    property p_fast;
        s_drive_to_fast |-> out1High == $past(out2High) && out1Low == $past(out2Low);
    endproperty
    a_fast: assert property (p_fast) else $error("fast decay does not reverse bridge");
    property p_min_drive; phase == 3'h0 && driveCnt < 12'h064 |=> phase == 3'h0; endproperty
    a_min_drive: assert property (p_min_drive) else $error("drive below blanking");
    property p_trip_exit;
        phase == 3'h0 && driveCnt > 12'h104 && tripCurrent |=> phase != 3'h0;
    endproperty
    a_trip_exit: assert property (p_trip_exit) else $error("trip ignored after blank");
    property p_valley; phase == 3'h4 && valleyCurrent |=> phase == 3'h0; endproperty
    a_valley: assert property (p_valley) else $error("valley reached but no drive");
    property p_pin_level;
        !serialMode |=> tripLevel == 8'((16'($past(extRefCode)) * 16'($past(sineWeight))) >> 8);
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin mode trip level wrong");
    property p_int_level;
        serialMode && intRefEn && !holding |=>
            tripLevel == lvl(INT_REF_CODE, $past(sineWeight), $past(torqueScale));
    endproperty
    a_int_level: assert property (p_int_level) else $error("internal ref level wrong");
endmodule

bind scc_chopper scc_chopper_assertions i_scc_chopper_assertions (
    .clk, .rstn, .serialMode, .torqueScale, .intRefEn, .holding, .extRefCode, .sineWeight,
    .direction, .tripCurrent, .valleyCurrent, .tripLevel, .out1High, .out1Low, .out2High,
    .out2Low, .phase
);

// ==== dv/scc_winding_model.sv ====
// behavioural winding and current comparators facing the chopper
`timescale 1ns/1ps
module scc_winding_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [2:0]  phase,
    input  wire logic [11:0] riseCyc,
    input  wire logic [11:0] holdCyc,
    input  wire logic [11:0] nzCyc,
    output logic             tripCurrent,
    output logic             valleyCurrent,
    output logic             nearZero
);
    logic [2:0]  lastPhase_reg;
    logic [11:0] cnt_reg;
    logic [11:0] age;
    // time in the present phase stands in for the current ramp; saturates on long holds
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lastPhase_reg <= 3'h0;
            cnt_reg       <= 12'h000;
        end else begin
            lastPhase_reg <= phase;
            if (phase != lastPhase_reg)
                cnt_reg <= 12'h001;
            else if (cnt_reg != 12'hFFF)
                cnt_reg <= cnt_reg + 12'h001;
        end
    end
    // a fresh phase reads zero, so the count of the previous phase never leaks in
    assign age = (phase != lastPhase_reg) ? 12'h000 : cnt_reg;
    // levels come from registers only, so they move just after an edge
    assign tripCurrent   = (phase == 3'h0 && age >= riseCyc)
                        || (phase == 3'h3 && age < holdCyc);
    assign valleyCurrent = phase == 3'h4 && age >= 12'h028;
    assign nearZero      = phase == 3'h1 && nzCyc != 12'h000 && age >= nzCyc;
endmodule

// ==== dv/test_stepper_current_chopper.sv ====
// self-checking bench for the current chopper
`timescale 1ns/1ps
module test_stepper_current_chopper
    import scc_pkg::*;
;
    logic        clk, rstn, serialMode, intRefEn, holding, direction;
    logic [7:0]  torqueScale, holdCurrentScale, extRefCode, sineWeight, tripLevel;
    logic [2:0]  decaySelect, phase;
    logic [1:0]  offIntervalCfg, blankingCfg, decayPinLow, decayPinHigh;
    logic        tripCurrent, valleyCurrent, nearZero, out1High, out1Low, out2High, out2Low;
    logic [6:0]  fastPct;
    logic [11:0] riseCyc, holdCyc, nzCyc;
    int          bad_count = 0;
    int          checked = 0;
    // mode table: serial code or pin pair, first decay phase, fast percent
    logic [2:0]  tCode [5] = '{DECAY_SLOW, DECAY_MIX30, DECAY_MIX60, DECAY_SLOW, DECAY_SLOW};
    logic        tSer [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [1:0]  tPl [5] = '{PIN_OPEN, PIN_OPEN, PIN_OPEN, PIN_OPEN, PIN_HIGH};
    logic [1:0]  tPh [5] = '{PIN_HIGH, PIN_HIGH, PIN_HIGH, PIN_HIGH, PIN_LOW};
    logic [2:0]  tFirst [5] = '{3'h3, 3'h1, 3'h1, 3'h3, 3'h1};
    int          tPct [5] = '{0, 30, 60, 0, 30};

    scc_chopper #(.LONG_DRIVE_CYC(150), .DYN_STEP_PCT(10)) i_scc_chopper (
        .clk, .rstn, .serialMode, .torqueScale, .holdCurrentScale, .decaySelect, .intRefEn,
        .offIntervalCfg, .blankingCfg, .decayPinLow, .decayPinHigh, .holding, .extRefCode,
        .sineWeight, .direction, .tripCurrent, .valleyCurrent, .nearZero, .tripLevel,
        .out1High, .out1Low, .out2High, .out2Low, .phase, .fastPct);
    scc_winding_model i_scc_winding_model (
        .clk, .rstn, .phase, .riseCyc, .holdCyc, .nzCyc, .tripCurrent, .valleyCurrent, .nearZero);

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // register write: 0 torque scale, 1 hold scale, 2 decay select
    task automatic wr_reg(input logic [1:0] addr, input logic [7:0] val);
        @(posedge clk);
        case (addr)
            2'h0: torqueScale <= val;
            2'h1: holdCurrentScale <= val;
            default: decaySelect <= val[2:0];
        endcase
    endtask

    // one whole chopping cycle: waits for drive, then times the decay; bounded
    task automatic measure(output int fastN, output int offN, output logic [2:0] first);
        int n;
        n = 0;
        fastN = 0;
        offN = 0;
        #1;
        while (phase !== 3'h0 && n < 9000) begin @(posedge clk); #1; n++; end
        while (phase === 3'h0 && n < 9000) begin @(posedge clk); #1; n++; end
        first = phase;
        while (phase !== 3'h0 && n < 9000) begin
            fastN += (phase === 3'h1);
            offN++;
            @(posedge clk); #1; n++;
        end
        if (n >= 9000) begin
            bad_count++;
            tally_and_finish();
        end
    endtask

    initial begin
        int f, o;
        logic [2:0] ph;
        logic [6:0] p0;
        {serialMode, intRefEn, holding, direction} = 4'h9;
        {torqueScale, holdCurrentScale, extRefCode, sineWeight} = 32'hFF4080FF;
        {offIntervalCfg, blankingCfg, decayPinLow, decayPinHigh} = {4'h0, PIN_OPEN, PIN_HIGH};
        {riseCyc, holdCyc, nzCyc} = 36'h0;
        decaySelect = DECAY_RESET;
        rstn = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check(16'(phase), 16'h0000);
        check(16'(fastPct), 16'(PCT_DYN_RESET));
        check(16'(tripLevel), 16'h0000);
        $display("reset test done");
        @(posedge clk);
        rstn <= 1'b1;
        measure(f, o, ph);
        check(16'(ph), 16'h0004);
        check(16'(f), 16'h0000);
        check(16'(o), 16'h0029);
        $display("ripple test done");
        // slow, 30% and 60% modes by serial code, slow and 30% by pins, switched while running, no reset between
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            serialMode <= tSer[i];
            decaySelect <= tCode[i];
            decayPinLow <= tPl[i];
            decayPinHigh <= tPh[i];
            measure(f, o, ph);
            measure(f, o, ph);
            check(16'(ph), 16'(tFirst[i]));
            check(16'(f), 16'(int'(OFF0_CYC) * tPct[i] / 100));
            check(16'(o), 16'(OFF0_CYC));
            $display("mode test %0d done", i);
        end
        @(posedge clk);
        {serialMode, decaySelect, nzCyc} <= {1'b1, DECAY_MIX60, 12'h014};
        measure(f, o, ph);
        measure(f, o, ph);
        check(16'(f), 16'h0015);
        check(16'(o), 16'(OFF0_CYC));
        @(posedge clk);
        {decaySelect, nzCyc, holdCyc} <= {DECAY_SLOW, 12'h000, 12'h3E8};
        measure(f, o, ph);
        measure(f, o, ph);
        check(16'(o), 16'(2 * int'(OFF0_CYC)));
        $display("fast and slow tests done");
        @(posedge clk);
        {decaySelect, holdCyc} <= {DECAY_DYNAMIC, 12'h000};
        measure(f, o, ph);
        p0 = fastPct;
        measure(f, o, ph);
        check(16'(fastPct), 16'(p0) + 16'h000A);
        riseCyc <= 12'h12C;
        measure(f, o, ph);
        p0 = fastPct;
        measure(f, o, ph);
        check(16'(fastPct), 16'(p0) - 16'h000A);
        riseCyc <= 12'h078;
        measure(f, o, ph);
        wr_reg(2'h0, 8'h80);
        measure(f, o, ph);
        check(16'(f), 16'(OFF0_CYC));
        $display("dynamic test done");
        check(16'(tripLevel), 16'h0040);
        @(posedge clk);
        {intRefEn, torqueScale, sineWeight} <= {1'b1, 16'hFFFF};
        repeat (2) @(posedge clk);
        #1 check(16'(tripLevel), 16'h00FE);
        wr_reg(2'h1, 8'h40);
        holding <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check(16'(tripLevel), 16'h0040);
        @(posedge clk);
        {serialMode, holding, sineWeight} <= {2'h0, 8'hC0};
        repeat (2) @(posedge clk);
        #1 check(16'(tripLevel), 16'h0060);
        $display("level test done");
        tally_and_finish();
    end
endmodule
